// >>> design/aps_core.sv
// converter pair skew, conversion placement, ready pulses and ready flags
`timescale 1ns/100ps
`include "aps_consts.svh"

module aps_core #(
  parameter int STEP_CYCLES = `APS_STEP_CYCLES,
  parameter int PULSE_CYCLES = `APS_PULSE_CYCLES,
  parameter int CHANNELS = 4
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic skew_wr_in,
  input wire logic [23:0] skew_wdata_in,
  input wire logic merge_wr_in,
  input wire logic merge_wdata_in,
  input wire logic status_rd_in,
  input wire logic [2:0] osr_sel_in,
  input wire logic [1:0] prescale_sel_in,
  input wire logic [3:0] channel_enable_in,
  input wire logic external_clock_select_in,
  output logic [23:0] pair_skew_register_out,
  output logic ready_merge_control_out,
  output logic [3:0] channel_ready_flags_out,
  output logic [3:0] latch_strobe_out,
  output logic converter_restart_out,
  output logic converters_held_out,
  output logic ready_pulse_pin_out,
  output logic ready_pulse_pin_oe_out,
  output logic oscillator_enable_out,
  output logic external_buffer_select_out,
  output logic crystal_output_pin_pulldown_out
);

  // configuration state
  logic [23:0] pair_skew_register;
  logic [23:0] next_pair_skew_register;
  logic ready_merge_control;
  logic next_ready_merge_control;
  logic restart;
  logic next_restart;

  // timing state
  logic [11:0] phase;
  logic [11:0] next_phase;
  logic [3:0] flags;
  logic [3:0] next_flags;
  logic [3:0] latch;
  logic [3:0] next_latch;
  logic pulse_trigger;
  logic next_pulse_trigger;

  // clock source state
  logic osc_en;
  logic next_osc_en;
  logic ext_sel;
  logic next_ext_sel;

  // derived values
  logic tick;
  logic [12:0] oversampling_ratio;
  logic [12:0] half;
  logic [12:0] skew_first;
  logic [12:0] skew_second;
  logic [11:0] pos_odd;
  logic [11:0] pos_first;
  logic [11:0] pos_second;
  logic [11:0] pos_lag;
  logic [12:0] lag_off;
  logic [11:0] phase_after;
  logic [3:0] chan_hit;
  logic [3:0] update;

  // sign bit sits at 4 + ratio select; bits above it copy the sign
  function automatic logic [12:0] skew_value(input logic [11:0] field,
                                             input logic [2:0] osr_sel);
    logic [12:0] v;
    int sign_pos;
    v = 13'h0000;
    sign_pos = `APS_SIGN_BIT_MIN + int'(osr_sel);
    for (int b = 0; b < 13; b++) begin
      if (b <= sign_pos) begin
        v[b] = field[b];
      end else begin
        v[b] = field[sign_pos];
      end
    end
    return v;
  endfunction

  // skew register and merge control
  always_comb begin
    next_pair_skew_register = pair_skew_register;
    next_ready_merge_control = ready_merge_control;
    next_restart = 1'b0;
    if (skew_wr_in) begin
      next_pair_skew_register = skew_wdata_in;
      // equal data still restarts, so software can use a rewrite as a resync
      next_restart = 1'b1;
    end
    if (merge_wr_in) begin
      next_ready_merge_control = merge_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pair_skew_register <= `APS_SKEW_RESET;
      ready_merge_control <= `APS_MERGE_RESET;
      restart <= 1'b0;
    end else begin
      pair_skew_register <= next_pair_skew_register;
      ready_merge_control <= next_ready_merge_control;
      restart <= next_restart;
    end
  end

  // one tick per modulator step
  aps_step_tick #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_step_tick (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .restart_in(restart),
    .prescale_sel_in(prescale_sel_in),
    .tick_out(tick)
  );

  // placement of conversion results within each output sample period
  always_comb begin
    oversampling_ratio = 13'(`APS_OSR_MIN << osr_sel_in);
    half = 13'(`APS_HALF_MIN << osr_sel_in);
    // fields are read with the sign at the ratio's own position
    skew_first = skew_value(pair_skew_register[`APS_FIRST_LSB +: `APS_FIELD_W],
                            osr_sel_in);
    skew_second = skew_value(pair_skew_register[`APS_SECOND_LSB +: `APS_FIELD_W],
                             osr_sel_in);
    // odd reference at half the ratio; even channels offset around it
    pos_odd = half[11:0];
    // range -half..half-1 keeps every position inside one period
    pos_first = 12'(half + skew_first);
    pos_second = 12'(half + skew_second);
    // most lagging active channel; odd channels count as offset zero
    lag_off = 13'h1000;
    if (channel_enable_in[1] || channel_enable_in[3]) begin
      lag_off = 13'h0000;
    end
    if (channel_enable_in[0] && ($signed(skew_first) > $signed(lag_off))) begin
      lag_off = skew_first;
    end
    if (channel_enable_in[2] && ($signed(skew_second) > $signed(lag_off))) begin
      lag_off = skew_second;
    end
    pos_lag = 12'(half + lag_off);
    phase_after = 12'(phase + 12'h001);
    if (13'(phase_after) >= oversampling_ratio) begin
      phase_after = 12'h000;
    end
    // odd channels compare against the same position, so when both are enabled they fire together
    chan_hit[0] = channel_enable_in[0] && (phase_after == pos_first);
    chan_hit[1] = channel_enable_in[1] && (phase_after == pos_odd);
    chan_hit[2] = channel_enable_in[2] && (phase_after == pos_second);
    chan_hit[3] = channel_enable_in[3] && (phase_after == pos_odd);
    if (!tick) begin
      update = 4'h0;
    end else if (ready_merge_control) begin
      // merged: every active channel latched at the lagging result
      if ((channel_enable_in != 4'h0) && (phase_after == pos_lag)) begin
        update = channel_enable_in;
      end else begin
        update = 4'h0;
      end
    end else begin
      update = chan_hit;
    end
  end

  always_comb begin
    next_phase = phase;
    if (restart) begin
      next_phase = 12'h000;
    end else if (tick) begin
      next_phase = phase_after;
    end
    next_latch = update;
    // clear wins: a fresh update clears a flag even in a read cycle
    for (int i = 0; i < CHANNELS; i++) begin
      if (update[i]) begin
        next_flags[i] = 1'b0;
      end else if (status_rd_in) begin
        next_flags[i] = 1'b1;
      end else begin
        next_flags[i] = flags[i];
      end
    end
    // several channels in one step give one pulse on the shared pin
    next_pulse_trigger = |update;
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      phase <= 12'h000;
      flags <= `APS_FLAGS_RESET;
      latch <= 4'h0;
      pulse_trigger <= 1'b0;
    end else begin
      phase <= next_phase;
      flags <= next_flags;
      latch <= next_latch;
      pulse_trigger <= next_pulse_trigger;
    end
  end

  // ready pin shaping, floated while reset is applied
  aps_ready_pulse #(
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_ready_pulse (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .trigger_in(pulse_trigger),
    .pin_out(ready_pulse_pin_out),
    .pin_oe_out(ready_pulse_pin_oe_out)
  );

  // clock source selection
  always_comb begin
    next_osc_en = !external_clock_select_in;
    next_ext_sel = external_clock_select_in;
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      osc_en <= !`APS_CLK_SEL_RESET;
      ext_sel <= `APS_CLK_SEL_RESET;
    end else begin
      osc_en <= next_osc_en;
      ext_sel <= next_ext_sel;
    end
  end

  // output registers
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      converters_held_out <= 1'b1;
      converter_restart_out <= 1'b0;
      latch_strobe_out <= 4'h0;
      channel_ready_flags_out <= `APS_FLAGS_RESET;
      pair_skew_register_out <= `APS_SKEW_RESET;
      ready_merge_control_out <= `APS_MERGE_RESET;
      oscillator_enable_out <= !`APS_CLK_SEL_RESET;
      external_buffer_select_out <= `APS_CLK_SEL_RESET;
      crystal_output_pin_pulldown_out <= `APS_CLK_SEL_RESET;
    end else begin
      converters_held_out <= 1'b0;
      converter_restart_out <= restart;
      latch_strobe_out <= latch;
      channel_ready_flags_out <= flags;
      pair_skew_register_out <= pair_skew_register;
      ready_merge_control_out <= ready_merge_control;
      oscillator_enable_out <= osc_en;
      external_buffer_select_out <= ext_sel;
      // weak pull on the crystal output only when the buffer path is used
      crystal_output_pin_pulldown_out <= ext_sel;
    end
  end

endmodule // aps_core

// >>> design/aps_consts.svh
// constants for the converter pair skew and ready timing block
`ifndef APS_CONSTS_SVH
`define APS_CONSTS_SVH

// clock and time base
`define APS_CLK_MHZ 200
`define APS_STEP_NS 1000
`define APS_STEP_CYCLES ((`APS_STEP_NS * `APS_CLK_MHZ) / 1000)
`define APS_PULSE_NS 100
`define APS_PULSE_CYCLES ((`APS_PULSE_NS * `APS_CLK_MHZ) / 1000)

// skew register layout
`define APS_SKEW_W 24
`define APS_FIELD_W 12
`define APS_FIRST_LSB 0
`define APS_SECOND_LSB 12
`define APS_SKEW_RESET 24'h000000

// oversampling ratio coding: ratio = 32 << select, sign bit = 4 + select
`define APS_OSR_MIN 13'h0020
`define APS_HALF_MIN 13'h0010
`define APS_SIGN_BIT_MIN 4

// reset values
`define APS_MERGE_RESET 1'b1
`define APS_FLAGS_RESET 4'hf
`define APS_CLK_SEL_RESET 1'b0

`endif

// >>> design/aps_pkg.sv
// types shared by the converter pair skew and ready timing block
package aps_pkg;

  typedef enum logic [1:0] {
    APS_PULSE_IDLE = 2'b01,
    APS_PULSE_LOW = 2'b10
  } aps_pulse_state_t;

endpackage

// >>> design/aps_step_tick.sv
// modulator step tick generator with prescale and restart
`timescale 1ns/100ps
`include "aps_consts.svh"

module aps_step_tick #(
  parameter int STEP_CYCLES = `APS_STEP_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic restart_in,
  input wire logic [1:0] prescale_sel_in,
  output logic tick_out
);

  logic [15:0] count;
  logic [15:0] next_count;
  logic next_tick;
  logic [15:0] limit;

  always_comb begin
    // one step period stretches with the prescaler, as the modulator clock does
    limit = 16'(STEP_CYCLES << prescale_sel_in) - 16'h0001;
    next_count = count + 16'h0001;
    next_tick = 1'b0;
    if (restart_in) begin
      next_count = 16'h0000;
    end else if (count >= limit) begin
      next_count = 16'h0000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      count <= 16'h0000;
      tick_out <= 1'b0;
    end else begin
      count <= next_count;
      tick_out <= next_tick;
    end
  end

endmodule // aps_step_tick

// >>> design/aps_ready_pulse.sv
// active-low fixed width ready pulse shaper with output enable
`timescale 1ns/100ps
`include "aps_consts.svh"

module aps_ready_pulse #(
  parameter int PULSE_CYCLES = `APS_PULSE_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic trigger_in,
  output logic pin_out,
  output logic pin_oe_out
);

  aps_pkg::aps_pulse_state_t state;
  aps_pkg::aps_pulse_state_t next_state;
  logic [7:0] count;
  logic [7:0] next_count;
  logic next_pin;

  always_comb begin
    next_state = state;
    next_count = count;
    next_pin = 1'b1;
    case (state)
      aps_pkg::APS_PULSE_IDLE: begin
        if (trigger_in) begin
          next_state = aps_pkg::APS_PULSE_LOW;
          next_count = 8'(PULSE_CYCLES - 1);
          next_pin = 1'b0;
        end
      end
      aps_pkg::APS_PULSE_LOW: begin
        // a trigger during a pulse is absorbed; events are a step period apart
        if (count == 8'h00) begin
          next_state = aps_pkg::APS_PULSE_IDLE;
        end else begin
          next_count = count - 8'h01;
          next_pin = 1'b0;
        end
      end
      default: begin
        next_state = aps_pkg::APS_PULSE_IDLE;
        next_count = 8'h00;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state <= aps_pkg::APS_PULSE_IDLE;
      count <= 8'h00;
      pin_out <= 1'b1;
      pin_oe_out <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      pin_out <= next_pin;
      pin_oe_out <= 1'b1;
    end
  end

endmodule // aps_ready_pulse

// >>> verif/aps_core_props.sv
// assertions for the pair skew and ready timing block
`timescale 1ns/100ps
module aps_core_props #(
  parameter int PULSE_CYCLES = 20
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic skew_wr_in,
  input wire logic status_rd_in,
  input wire logic [3:0] channel_enable_in,
  input wire logic external_clock_select_in,
  input wire logic ready_merge_control_out,
  input wire logic [3:0] channel_ready_flags_out,
  input wire logic [3:0] latch_strobe_out,
  input wire logic converter_restart_out,
  input wire logic ready_pulse_pin_out,
  input wire logic oscillator_enable_out,
  input wire logic external_buffer_select_out,
  input wire logic crystal_output_pin_pulldown_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  int low_cnt;
  int next_low_cnt;
  // a counter keeps the width check free of long repetitions
  always_comb next_low_cnt = (reset_in || ready_pulse_pin_out) ? 0 : low_cnt + 1;
  always_ff @(posedge ref_clk_in) low_cnt <= next_low_cnt;
  sequence s_restart; ##2 converter_restart_out; endsequence
  // pin falls on the same edge that launches the latch strobe
  sequence s_pin_low; !ready_pulse_pin_out && $past(ready_pulse_pin_out); endsequence
  property p_restart; skew_wr_in |-> s_restart; endproperty
  a_restart: assert property (p_restart) else $error("no restart after skew write");
  property p_pin_fall; (|latch_strobe_out) |-> s_pin_low; endproperty
  a_pin_fall: assert property (p_pin_fall) else $error("ready pin did not fall");
  property p_width; $rose(ready_pulse_pin_out) |-> low_cnt == PULSE_CYCLES; endproperty
  a_width: assert property (p_width) else $error("ready pulse width wrong");
  property p_flag_clr; |latch_strobe_out |-> (channel_ready_flags_out & latch_strobe_out) == 4'h0;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared on update");
  property p_rearm; status_rd_in |-> ##2 ((channel_ready_flags_out | latch_strobe_out) == 4'hf);
  endproperty
  a_rearm: assert property (p_rearm) else $error("flags not rearmed by read");
  property p_odd; (channel_enable_in[1] && channel_enable_in[3])
    |-> latch_strobe_out[1] == latch_strobe_out[3]; endproperty
  a_odd: assert property (p_odd) else $error("odd channels not together");
  property p_merged; (ready_merge_control_out && |latch_strobe_out)
    |-> latch_strobe_out == channel_enable_in; endproperty
  a_merged: assert property (p_merged) else $error("merged latch not common");
  property p_ext; external_clock_select_in |-> ##2 (external_buffer_select_out
    && crystal_output_pin_pulldown_out && !oscillator_enable_out); endproperty
  a_ext: assert property (p_ext) else $error("external clock path wrong");
  property p_xtal; !external_clock_select_in |-> ##2 (oscillator_enable_out
    && !external_buffer_select_out && !crystal_output_pin_pulldown_out); endproperty
  a_xtal: assert property (p_xtal) else $error("crystal path wrong");
endmodule // aps_core_props

bind aps_core aps_core_props #(.PULSE_CYCLES(PULSE_CYCLES)) i_aps_core_props (
  .ref_clk_in, .reset_in, .skew_wr_in, .status_rd_in, .channel_enable_in,
  .external_clock_select_in, .ready_merge_control_out, .channel_ready_flags_out,
  .latch_strobe_out, .converter_restart_out, .ready_pulse_pin_out,
  .oscillator_enable_out, .external_buffer_select_out, .crystal_output_pin_pulldown_out);

// >>> verif/aps_host_model.sv
// host model that rearms the ready flags one cycle after each fall of the ready pin, while enabled
`timescale 1ns/100ps
module aps_host_model (
  input wire logic ref_clk_in,
  input wire logic enable_in,
  input wire logic ready_pulse_pin_in,
  output logic status_rd_out,
  output int reads_out
);
  logic pin_q = 1'b1;
  initial status_rd_out = 1'b0;
  initial reads_out = 0;
  always @(posedge ref_clk_in) begin
    pin_q <= ready_pulse_pin_in;
    status_rd_out <= enable_in && pin_q && !ready_pulse_pin_in;
    if (status_rd_out) reads_out <= reads_out + 1;
  end
endmodule // aps_host_model

// >>> verif/aps_core_test.sv
// self-checking bench for the pair skew and ready timing block
`timescale 1ns/100ps
module aps_core_test;
  localparam int STEP = 4;
  typedef struct {
    logic [2:0] oversampling_ratio;
    logic [1:0] pre;
    logic [11:0] a;
    logic [11:0] b;
    int sa;
    int sb;
    int np;
  } aps_row_t;
  aps_row_t rows[4] = '{
    '{3'h0, 2'h0, 12'h005, 12'hffd, 5, -3, 3},
    '{3'h0, 2'h1, 12'h00f, 12'h011, 15, -15, 3},
    '{3'h1, 2'h0, 12'h01f, 12'h821, 31, -31, 3},
    '{3'h2, 2'h0, 12'h000, 12'h03f, 0, 63, 2}};
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic skew_wr_in = 1'b0;
  logic [23:0] skew_wdata_in = 24'h000000;
  logic merge_wr_in = 1'b0;
  logic merge_wdata_in = 1'b0;
  logic status_rd_in;
  logic [2:0] osr_sel_in = 3'h0;
  logic [1:0] prescale_sel_in = 2'h0;
  logic [3:0] channel_enable_in = 4'hf;
  logic external_clock_select_in = 1'b0;
  logic host_en = 1'b0;
  logic [23:0] pair_skew_register_out;
  logic [3:0] channel_ready_flags_out, latch_strobe_out;
  logic ready_merge_control_out, converter_restart_out, converters_held_out;
  logic ready_pulse_pin_out, ready_pulse_pin_oe_out, oscillator_enable_out;
  logic external_buffer_select_out, crystal_output_pin_pulldown_out;
  int error_cnt = 0;
  int checks = 0;
  int reads, cst, falls, c;
  int t[4];
  always #2.5 ref_clk_in = ~ref_clk_in;
  aps_core #(.STEP_CYCLES(STEP), .PULSE_CYCLES(2)) i_aps_core (.ref_clk_in, .reset_in,
    .skew_wr_in, .skew_wdata_in, .merge_wr_in, .merge_wdata_in, .status_rd_in, .osr_sel_in,
    .prescale_sel_in, .channel_enable_in, .external_clock_select_in, .pair_skew_register_out,
    .ready_merge_control_out, .channel_ready_flags_out, .latch_strobe_out,
    .converter_restart_out, .converters_held_out, .ready_pulse_pin_out,
    .ready_pulse_pin_oe_out, .oscillator_enable_out, .external_buffer_select_out,
    .crystal_output_pin_pulldown_out);
  aps_host_model i_aps_host_model (.ref_clk_in, .enable_in(host_en),
    .ready_pulse_pin_in(ready_pulse_pin_out), .status_rd_out(status_rd_in), .reads_out(reads));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic timed_out();
    error_cnt++;
    $display("CHECK FAILED at %0t: wait bound used up", $time);
    print_verdict();
  endtask
  // merge and skew written in one cycle so no stale mode sees new events
  task automatic configure(input logic m, input logic [23:0] v);
    @(posedge ref_clk_in);
    skew_wr_in <= 1'b1;
    merge_wr_in <= 1'b1;
    merge_wdata_in <= m;
    skew_wdata_in <= v;
    @(posedge ref_clk_in);
    skew_wr_in <= 1'b0;
    merge_wr_in <= 1'b0;
  endtask
  task automatic wait_latch(output int n);
    for (n = 1; n < 1200; n++) begin
      @(posedge ref_clk_in);
      #1;
      if (|latch_strobe_out === 1'b1) return;
    end
    timed_out();
  endtask
  task automatic do_reset(input int n);
    @(posedge ref_clk_in);
    reset_in <= 1'b1;
    repeat (n) @(posedge ref_clk_in);
    #1;
    chk({converters_held_out, ready_pulse_pin_oe_out, ready_pulse_pin_out,
      channel_ready_flags_out, ready_merge_control_out, oscillator_enable_out,
      external_buffer_select_out, crystal_output_pin_pulldown_out}, 11'h5fc);
    chk(pair_skew_register_out, 24'h000000);
    @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    #1;
    chk({converters_held_out, ready_pulse_pin_oe_out}, 2'h1);
    $display("reset test done");
  endtask
  task automatic run_row(input aps_row_t r, input bit first);
    int last;
    int stp;
    logic pin_prev;
    stp = STEP << r.pre;
    for (int i = 0; i < 4; i++) t[i] = -1;
    falls = 0;
    last = 1200;
    pin_prev = 1'b1;
    @(posedge ref_clk_in);
    osr_sel_in <= r.oversampling_ratio;
    prescale_sel_in <= r.pre;
    configure(1'b0, {r.b, r.a});
    // early samples may hold strobes launched before the restart
    for (int n = 1; n < last + 5; n++) begin
      @(posedge ref_clk_in);
      #1;
      for (int i = 0; i < 4; i++)
        if (latch_strobe_out[i] === 1'b1 && t[i] < 0 && n > 3) t[i] = n;
      if (n > 4 && pin_prev === 1'b1 && ready_pulse_pin_out === 1'b0) falls++;
      pin_prev = ready_pulse_pin_out;
      if (t[0] > 0 && t[1] > 0 && t[2] > 0 && t[3] > 0 && last == 1200) last = n;
    end
    if (last == 1200) timed_out();
    if (first) cst = t[1] - 16 * STEP;
    chk(pair_skew_register_out, {r.b, r.a});
    chk(t[3], t[1]);
    chk(t[1], cst + (16 << r.oversampling_ratio) * stp);
    chk(t[0] - t[1], r.sa * stp);
    chk(t[2] - t[3], r.sb * stp);
    chk(falls, r.np);
    chk(channel_ready_flags_out, 4'h0);
    $display("row test done");
  endtask
  initial begin
    do_reset(6);
    for (int i = 0; i < 4; i++) run_row(rows[i], i == 0);
    @(posedge ref_clk_in);
    channel_enable_in <= 4'hb;
    host_en <= 1'b1;
    osr_sel_in <= 3'h0;
    prescale_sel_in <= 2'h0;
    configure(1'b1, 24'h008005);
    configure(1'b1, 24'h008005);
    wait_latch(c);
    chk(c, cst + 21 * STEP);
    chk(latch_strobe_out, 4'hb);
    repeat (6) @(posedge ref_clk_in);
    #1;
    chk(channel_ready_flags_out, 4'hf);
    chk(reads, 1);
    wait_latch(c);
    chk(channel_ready_flags_out, 4'h4);
    $display("merged test done");
    @(posedge ref_clk_in);
    external_clock_select_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk({oscillator_enable_out, external_buffer_select_out,
      crystal_output_pin_pulldown_out}, 3'h3);
    @(posedge ref_clk_in);
    external_clock_select_in <= 1'b0;
    $display("clock select test done");
    do_reset(2);
    print_verdict();
  end
endmodule // aps_core_test
